// >>> rtl/term_level_ctrl.sv
// Termination control and write leveling feedback of the memory device.
`timescale 1ns/10ps
module term_level_ctrl (
  // Clock and reset
  input  wire logic                                clock,
  input  wire logic                                rst_n,
  // Pins from the controller
  input  wire term_level_pkg::link_pins_s          pins,
  // Mode and latency settings
  input  wire logic [4:0]                          write_cas_latency,
  input  wire logic [4:0]                          additive_latency,
  input  wire logic                                dll_off_pd,
  input  wire logic                                leveling_mode,
  // Termination and feedback
  output term_level_pkg::term_level_e              termination_resistance,
  output logic [term_level_pkg::DQ_W-1:0]          lvl_dq_o,
  output logic [term_level_pkg::DQ_W-1:0]          lvl_dq_oe
);

  localparam int H = term_level_pkg::HIST_DEPTH;

  typedef struct packed {
    logic [H-1:0]                       en_hist;
    logic [H-1:0]                       wr_hist;
    logic [H-1:0]                       chop_hist;
    term_level_pkg::term_level_e        level;
    term_level_pkg::term_level_e        pend;
    logic                               settling;
    logic [term_level_pkg::PER_W-1:0]   settle_cnt;
    logic                               fb_val;
    logic                               fb_oe;
  } ctrl_s;

  ctrl_s                            st_r;
  ctrl_s                            st_nxt;
  term_level_pkg::link_pins_s       smp;
  logic                             link_tick;
  logic                             dqs_rise;
  logic [term_level_pkg::PER_W-1:0] half_period;
  logic [5:0]                       lat_sum;
  logic [5:0]                       lat;
  logic [H-1:0]                     en_sh;
  logic [H-1:0]                     wr_sh;
  logic [H-1:0]                     chop_sh;
  logic [H-1:0]                     hit;
  logic                             win;
  logic                             en_at_lat;
  term_level_pkg::term_level_e      tgt;

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  link_sampler u_sampler (
    .clock       (clock),
    .rst_n       (rst_n),
    .pins        (pins),
    .smp         (smp),
    .link_tick   (link_tick),
    .dqs_rise    (dqs_rise),
    .half_period (half_period)
  );

  // ----------------------------------------------------------------
  // Latency and sample histories
  // ----------------------------------------------------------------
  // Latency is clamped so that the longest write window fits the history.
  assign lat_sum = 6'(write_cas_latency) + 6'(additive_latency);
  assign lat     = (lat_sum < term_level_pkg::LAT_OFFSET) ? 6'h00
                   : (lat_sum - term_level_pkg::LAT_OFFSET > term_level_pkg::LAT_MAX)
                   ? term_level_pkg::LAT_MAX : lat_sum - term_level_pkg::LAT_OFFSET;

  // Each rising link edge registers enable, write and chop; age counts link clocks.
  assign en_sh   = link_tick ? {st_r.en_hist[H-2:0], smp.term_enable} : st_r.en_hist;
  assign wr_sh   = link_tick ? {st_r.wr_hist[H-2:0], smp.wr_cmd} : st_r.wr_hist;
  assign chop_sh = link_tick ? {st_r.chop_hist[H-2:0], smp.chop_cmd} : st_r.chop_hist;
  assign en_at_lat = en_sh[lat[4:0]];

  // Write termination window per history entry.
  genvar gi;
  generate
    for (gi = 0; gi < H; gi++) begin : g_win
      assign hit[gi] = wr_sh[gi] && (6'(gi) >= lat)
                       && (6'(gi) < lat + (chop_sh[gi] ? term_level_pkg::CHOP_EXTRA
                                                       : term_level_pkg::LONG_EXTRA));
    end
  endgenerate
  assign win = |hit;

  // Target value at this link edge.
  always_comb begin
    tgt = term_level_pkg::TERM_OFF;
    if (en_at_lat) begin
      tgt = win ? term_level_pkg::TERM_WR : term_level_pkg::TERM_NOM;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Outside power-down with the loop off, turn-on lands on the latency edge; turn-off and value changes wait half a link clock.
  always_comb begin
    st_nxt           = st_r;
    st_nxt.en_hist   = en_sh;
    st_nxt.wr_hist   = wr_sh;
    st_nxt.chop_hist = chop_sh;
    if (dll_off_pd) begin
      st_nxt.settling = 1'b0;
      st_nxt.level    = smp.term_enable ? term_level_pkg::TERM_NOM
                        : term_level_pkg::TERM_OFF;
    end else if (link_tick) begin
      if (tgt == st_r.level) begin
        st_nxt.settling = 1'b0;
      end else if (st_r.level == term_level_pkg::TERM_OFF) begin
        st_nxt.level    = tgt;
        st_nxt.settling = 1'b0;
      end else begin
        st_nxt.pend       = tgt;
        st_nxt.settle_cnt = half_period;
        st_nxt.settling   = 1'b1;
      end
    end else if (st_r.settling) begin
      if (st_r.settle_cnt <= 8'h01) begin
        st_nxt.level    = st_r.pend;
        st_nxt.settling = 1'b0;
      end else begin
        st_nxt.settle_cnt = st_r.settle_cnt - 8'h01;
      end
    end
    // Leveling: the strobe samples the link clock level.
    st_nxt.fb_oe = leveling_mode;
    if (leveling_mode && dqs_rise) begin
      st_nxt.fb_val = smp.link_clk;
    end
  end

  // State register.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r       <= '0;
      st_r.level <= term_level_pkg::TERM_OFF;
      st_r.pend  <= term_level_pkg::TERM_OFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every data line carries the same flop, so they switch on one edge.
  assign termination_resistance = st_r.level;
  assign lvl_dq_o  = {term_level_pkg::DQ_W{st_r.fb_val}};
  assign lvl_dq_oe = {term_level_pkg::DQ_W{st_r.fb_oe}};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_ASYNC_FOLLOW: assert property (
    dll_off_pd && $past(dll_off_pd) && $past(dll_off_pd, 2) && $past(dll_off_pd, 3)
    |-> (termination_resistance == ($past(pins.term_enable, 3) ? term_level_pkg::TERM_NOM
                                                               : term_level_pkg::TERM_OFF)))
    else $error("Async termination did not follow enable.");
  AST_ON_LATENCY: assert property (
    link_tick && !dll_off_pd && st_r.level == term_level_pkg::TERM_OFF && en_at_lat
    |=> termination_resistance != term_level_pkg::TERM_OFF)
    else $error("Termination did not turn on at latency.");
  AST_OFF_NOT_EARLY: assert property (
    link_tick && !dll_off_pd && st_r.level != term_level_pkg::TERM_OFF && !en_at_lat
    |=> termination_resistance != term_level_pkg::TERM_OFF ##0 st_r.settling)
    else $error("Termination removed without settle time.");
  AST_SETTLE_DONE: assert property (
    !dll_off_pd && !link_tick && st_r.settling && st_r.settle_cnt == 8'h01
    |=> termination_resistance == $past(st_r.pend))
    else $error("Pending termination change not applied.");
  AST_SETTLE_HALF: assert property (
    link_tick && !dll_off_pd && st_r.level != term_level_pkg::TERM_OFF && !en_at_lat
    |=> st_r.settle_cnt == $past(half_period))
    else $error("Settle delay is not half a link clock.");
  AST_WR_SWITCH: assert property (
    link_tick && !dll_off_pd && en_at_lat && wr_sh[lat[4:0]]
    && st_r.level == term_level_pkg::TERM_NOM
    |=> st_r.settling && st_r.pend == term_level_pkg::TERM_WR)
    else $error("Write termination not scheduled.");
  AST_CHOP_RETURN: assert property (
    link_tick && !dll_off_pd && en_at_lat && !win && st_r.level == term_level_pkg::TERM_WR
    && wr_sh[5'(lat + term_level_pkg::CHOP_EXTRA)]
    && chop_sh[5'(lat + term_level_pkg::CHOP_EXTRA)]
    |=> st_r.settling && st_r.pend == term_level_pkg::TERM_NOM)
    else $error("Chopped write did not return to nominal.");
  AST_LONG_HOLDS: assert property (
    link_tick && !dll_off_pd && en_at_lat && st_r.level == term_level_pkg::TERM_WR
    && wr_sh[5'(lat + term_level_pkg::CHOP_EXTRA)]
    && !chop_sh[5'(lat + term_level_pkg::CHOP_EXTRA)]
    |=> !st_r.settling && termination_resistance == term_level_pkg::TERM_WR)
    else $error("Long write window closed too early.");
  AST_LONG_RETURN: assert property (
    link_tick && !dll_off_pd && en_at_lat && !win && st_r.level == term_level_pkg::TERM_WR
    && wr_sh[5'(lat + term_level_pkg::LONG_EXTRA)]
    && !chop_sh[5'(lat + term_level_pkg::LONG_EXTRA)]
    |=> st_r.settling && st_r.pend == term_level_pkg::TERM_NOM)
    else $error("Long write did not return to nominal.");
  AST_LVL_FEEDBACK: assert property (
    leveling_mode && dqs_rise |=> lvl_dq_o[0] == $past(smp.link_clk) ##0 lvl_dq_oe[0])
    else $error("Leveling feedback mismatch.");
  AST_LVL_SPREAD: assert property (
    $changed(lvl_dq_o) |-> $past(leveling_mode) && $past(dqs_rise)
                           && lvl_dq_o == {term_level_pkg::DQ_W{lvl_dq_o[0]}})
    else $error("Leveling feedback lines changed apart or off a strobe.");

  COV_ON: cover property (
    termination_resistance == term_level_pkg::TERM_OFF
    ##1 termination_resistance == term_level_pkg::TERM_NOM);
  COV_WR: cover property (
    termination_resistance == term_level_pkg::TERM_WR
    ##1 termination_resistance == term_level_pkg::TERM_NOM);
  COV_ASYNC: cover property (dll_off_pd && termination_resistance == term_level_pkg::TERM_NOM);
  COV_LVL: cover property (leveling_mode && dqs_rise ##1 lvl_dq_o[0]);

endmodule

// >>> rtl/term_level_pkg.sv
// Shared constants, types and carriers for the termination and leveling block.
package term_level_pkg;

  // ----------------------------------------------------------------
  // Clock and time conversion
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 10000;
  localparam int ASYNC_MIN_PS     = 2000;
  localparam int ASYNC_MAX_PS     = 8500;
  localparam int FB_DELAY_MAX_PS  = 9000;
  localparam int FB_FAST_MAX_PS   = 7500;
  localparam int FB_SPREAD_MAX_PS = 2000;
  // Least times round up, longest times round down, never below one cycle.
  localparam int ASYNC_MIN_CYC = (ASYNC_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ASYNC_MAX_CYC = (ASYNC_MAX_PS / CLK_PERIOD_PS < 1) ? 1
                                 : ASYNC_MAX_PS / CLK_PERIOD_PS;
  localparam int FB_DELAY_CYC  = (FB_FAST_MAX_PS / CLK_PERIOD_PS < 1) ? 1
                                 : FB_FAST_MAX_PS / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Link clock counts
  // ----------------------------------------------------------------
  localparam logic [5:0] LAT_OFFSET   = 6'h02;
  localparam logic [5:0] LAT_MAX      = 6'h19;
  localparam logic [5:0] CHOP_EXTRA   = 6'h04;
  localparam logic [5:0] LONG_EXTRA   = 6'h06;
  localparam int         HOLD_LONG_CK = 6;
  localparam int         HOLD_SHORT_CK = 4;
  localparam int         LVL_WAIT_CK  = 40;
  localparam int         HIST_DEPTH   = 32;
  localparam int         PER_W        = 8;
  localparam int         DQ_W         = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [PER_W-1:0] HALF_RST = 8'h01;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Gray coded along off, nominal, write.
  typedef enum logic [1:0] {
    TERM_OFF = 2'h0,
    TERM_NOM = 2'h1,
    TERM_WR  = 2'h3
  } term_level_e;

  typedef struct packed {
    logic link_clk;
    logic term_enable;
    logic wr_cmd;
    logic chop_cmd;
    logic dqs;
  } link_pins_s;

endpackage

// >>> rtl/link_sampler.sv
// Synchroniser and edge finder for the pins driven by the memory controller.
`timescale 1ns/10ps
module link_sampler (
  // Clock and reset
  input  wire logic                                  clock,
  input  wire logic                                  rst_n,
  // Raw pins
  input  wire term_level_pkg::link_pins_s            pins,
  // Sampled view
  output term_level_pkg::link_pins_s                 smp,
  output logic                                       link_tick,
  output logic                                       dqs_rise,
  output logic [term_level_pkg::PER_W-1:0]           half_period
);

  typedef struct packed {
    term_level_pkg::link_pins_s         s1;
    term_level_pkg::link_pins_s         s2;
    logic                               clk_prev;
    logic                               dqs_prev;
    logic [term_level_pkg::PER_W-1:0]   per_cnt;
    logic [term_level_pkg::PER_W-1:0]   half;
  } samp_s;

  samp_s st_r;
  samp_s st_nxt;

  // ----------------------------------------------------------------
  // Edge detection and link period measurement
  // ----------------------------------------------------------------
  // Edges are found on the second stage only; the first stage feeds nothing else.
  assign link_tick   = st_r.s2.link_clk && !st_r.clk_prev;
  assign dqs_rise    = st_r.s2.dqs && !st_r.dqs_prev;
  assign smp         = st_r.s2;
  assign half_period = st_r.half;

  // Next state: two flops per pin, then period counting between rising link edges.
  always_comb begin
    st_nxt          = st_r;
    st_nxt.s1       = pins;
    st_nxt.s2       = st_r.s1;
    st_nxt.clk_prev = st_r.s2.link_clk;
    st_nxt.dqs_prev = st_r.s2.dqs;
    if (link_tick) begin
      st_nxt.per_cnt = '0;
      // Halving before the round-up keeps a saturated count from wrapping to zero.
      st_nxt.half    = (st_r.per_cnt < 8'h02) ? term_level_pkg::HALF_RST
                       : {1'b0, st_r.per_cnt[7:1]} + {7'h00, st_r.per_cnt[0]};
    end else if (st_r.per_cnt != 8'hFF) begin
      st_nxt.per_cnt = st_r.per_cnt + 8'h01;
    end
  end

  // State register.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= '0;
      st_r.half <= term_level_pkg::HALF_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// >>> dv/ctrl_model.sv
// Behavioural memory controller that clocks the link and drives the termination and strobe pins.
`timescale 1ns/10ps
module ctrl_model (
  // System clock, used only to place pin changes away from its sampling edge
  input  wire logic                  clock,
  // Pins toward the device
  output term_level_pkg::link_pins_s pins
);
  int   high_cnt  = 0;
  logic long_seen = 1'b0;

  // ----------------------------------------------------------------
  // Link clock
  // ----------------------------------------------------------------
  // The command clock starts after reset has gone and then runs free.
  initial begin
    pins = '0;
    #80.1;
    forever #62.5 pins.link_clk = ~pins.link_clk;
  end

  // Counts link clocks during which termination has been enabled.
  always @(posedge pins.link_clk) begin
    high_cnt <= pins.term_enable ? high_cnt + 1 : 0;
  end

  // ----------------------------------------------------------------
  // Pin tasks
  // ----------------------------------------------------------------
  // Changes enable and command at a link falling edge; never drops enable too early.
  task automatic drive(input logic en, input logic wr, input logic chop);
    while (pins.term_enable && !en
           && high_cnt < (long_seen ? term_level_pkg::HOLD_LONG_CK
                                    : term_level_pkg::HOLD_SHORT_CK)) begin
      @(posedge pins.link_clk);
    end
    @(negedge pins.link_clk);
    @(negedge clock);
    pins.term_enable = en;
    pins.wr_cmd      = wr;
    pins.chop_cmd    = chop;
    long_seen        = (long_seen || (wr && !chop)) && en;
  endtask

  // Changes enable at once, as in power-down with the loop off.
  task automatic set_now(input logic en);
    @(negedge clock);
    pins.term_enable = en;
  endtask

  // Waits the settling time after leveling entry before any strobe edge.
  task automatic level_entry_wait();
    repeat (term_level_pkg::LVL_WAIT_CK) @(posedge pins.link_clk);
  endtask

  // Raises the strobe while the link clock is high or low, as asked.
  task automatic strobe(input logic at_high);
    @(negedge clock);
    pins.dqs = 1'b0;
    repeat (2) @(negedge clock);
    if (at_high) begin
      @(posedge pins.link_clk);
    end else begin
      @(negedge pins.link_clk);
    end
    @(negedge clock);
    pins.dqs = 1'b1;
  endtask
endmodule

// >>> dv/term_level_ctrl_bench.sv
// Self-checking bench for termination timing and write leveling feedback.
`timescale 1ns/10ps
module term_level_ctrl_bench;
  // Latency is write CAS 3 plus additive 1, less two link clocks.
  localparam int LAT   = 2;
  // Sample points after a link rise in system clocks: early rounds down, late rounds up.
  localparam int EARLY = (3 * 125) / 100;
  localparam int LATE  = (7 * 125 + 99) / 100 + 2;
  localparam int LIMIT = 10000;

  logic                              clock;
  logic                              rst_n;
  logic                              dll_off_pd;
  logic                              leveling_mode;
  logic [4:0]                        write_cas_latency;
  logic [4:0]                        additive_latency;
  term_level_pkg::link_pins_s        pins;
  term_level_pkg::term_level_e       termination_resistance;
  logic [term_level_pkg::DQ_W-1:0]   lvl_dq_o;
  logic [term_level_pkg::DQ_W-1:0]   lvl_dq_oe;
  int                                n_fail     = 0;
  int                                n_compared = 0;
  int                                cycles     = 0;

  // ----------------------------------------------------------------
  // Device, controller model and clock
  // ----------------------------------------------------------------
  term_level_ctrl u_dut (
    .clock                  (clock),
    .rst_n                  (rst_n),
    .pins                   (pins),
    .write_cas_latency      (write_cas_latency),
    .additive_latency       (additive_latency),
    .dll_off_pd             (dll_off_pd),
    .leveling_mode          (leveling_mode),
    .termination_resistance (termination_resistance),
    .lvl_dq_o               (lvl_dq_o),
    .lvl_dq_oe              (lvl_dq_oe)
  );

  ctrl_model u_ctrl (
    .clock (clock),
    .pins  (pins)
  );

  // The system clock toggles every 5 ns.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Common tasks
  // ----------------------------------------------------------------
  // Counts a comparison and reports a mismatch at once.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("ERROR %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Compares the termination level with the one expected.
  task automatic term_is(input term_level_pkg::term_level_e exp, input string what);
    check({6'h00, termination_resistance}, {6'h00, exp}, what);
  endtask

  // Waits n link rises, then ofs system clocks, and stops at a falling edge.
  task automatic sample(input int n, input int ofs);
    repeat (n) @(posedge pins.link_clk);
    repeat (ofs) @(posedge clock);
    @(negedge clock);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Enable high: termination appears exactly the latency later.
  task automatic test_turn_on(input int lat);
    u_ctrl.drive(1'b1, 1'b0, 1'b0);
    sample(lat, LATE);
    term_is(term_level_pkg::TERM_OFF, "on one clock early");
    sample(1, EARLY - 1);
    term_is(term_level_pkg::TERM_OFF, "on before latency edge registered");
    sample(0, LATE - EARLY + 1);
    term_is(term_level_pkg::TERM_NOM, "on at latency");
  endtask

  // A write switches to write termination and back after its burst.
  task automatic test_write(input logic chop, input int beats);
    u_ctrl.drive(1'b1, 1'b1, chop);
    u_ctrl.drive(1'b1, 1'b0, 1'b0);
    sample(LAT, EARLY);
    term_is(term_level_pkg::TERM_NOM, "write switch too early");
    sample(0, LATE - EARLY);
    term_is(term_level_pkg::TERM_WR, "write switch missing");
    sample(beats - 1, LATE);
    term_is(term_level_pkg::TERM_WR, "write ended early");
    sample(1, EARLY);
    term_is(term_level_pkg::TERM_WR, "write return too early");
    sample(0, LATE - EARLY);
    term_is(term_level_pkg::TERM_NOM, "write return missing");
  endtask

  // Enable low: termination goes the latency later, within the settle window.
  task automatic test_turn_off(input int lat);
    u_ctrl.drive(1'b0, 1'b0, 1'b0);
    sample(lat, LATE);
    term_is(term_level_pkg::TERM_NOM, "off one clock early");
    sample(1, EARLY);
    term_is(term_level_pkg::TERM_NOM, "off settled too soon");
    sample(0, LATE - EARLY);
    term_is(term_level_pkg::TERM_OFF, "off not settled");
  endtask

  // Power-down with the loop off: termination follows enable without latency.
  task automatic test_async();
    @(negedge clock);
    dll_off_pd = 1'b1;
    u_ctrl.set_now(1'b1);
    sample(0, 3);
    term_is(term_level_pkg::TERM_NOM, "async on late");
    u_ctrl.set_now(1'b0);
    sample(0, 3);
    term_is(term_level_pkg::TERM_OFF, "async off late");
    dll_off_pd = 1'b0;
    sample(4, 0);
  endtask

  // Leveling: each strobe rise returns the link clock level on every data line.
  task automatic test_leveling();
    leveling_mode = 1'b1;
    u_ctrl.level_entry_wait();
    check(lvl_dq_oe, 8'hFF, "feedback not driven");
    for (int hi = 1; hi >= 0; hi--) begin
      u_ctrl.strobe(hi[0]);
      sample(0, 1);
      check(lvl_dq_o, {8{~hi[0]}}, "feedback changed early");
      sample(0, 2);
      check(lvl_dq_o, {8{hi[0]}}, "feedback wrong or late");
    end
    leveling_mode = 1'b0;
    sample(0, 2);
    check(lvl_dq_oe, 8'h00, "feedback still driven");
  endtask

  // ----------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Cuts a hang short after a fixed number of system clocks.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_fail = n_fail + 1;
      $display("ERROR %0t timeout", $time);
      finish_test();
    end
  end

  // Resets the device, then runs every scenario.
  initial begin
    rst_n             = 1'b0;
    dll_off_pd        = 1'b0;
    leveling_mode     = 1'b0;
    write_cas_latency = 5'h03;
    additive_latency  = 5'h01;
    repeat (6) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    sample(4, 0);
    test_turn_on(LAT);
    test_write(1'b1, 4);
    test_write(1'b0, 6);
    test_turn_off(LAT);
    // A second latency, write CAS 5 and no additive, changed only while termination is off.
    write_cas_latency = 5'h05;
    additive_latency  = 5'h00;
    sample(4, 0);
    test_turn_on(LAT + 1);
    test_turn_off(LAT + 1);
    test_async();
    test_leveling();
    finish_test();
  end
endmodule
